/* rtl/sensor_i2c_target_port.sv */
// Two-wire target port giving a bus controller access to the register space
`timescale 1ns/100ps
module sensor_i2c_target_port
  import i2c_target_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic ifaceSelect,
  input wire logic addressStrapPin,
  output i2c_target_pkg::reg_access_t regAccess,
  input wire logic [7:0] regRdData,
  output logic busBusy
);
  import i2c_target_pkg::*;

  typedef enum logic [5:0] {
    IDLE = 6'b000001,
    ADDR = 6'b000010,
    ACK = 6'b000100,
    RXBYTE = 6'b001000,
    TXBYTE = 6'b010000,
    MACK = 6'b100000
  } phase_t;

  typedef struct packed {
    phase_t phase;
    logic [7:0] shift;
    logic [2:0] bitCnt;
    logic sawRise;
    logic [7:0] ptr;
    logic gotPtr;
    logic readMode;
    logic ackDriven;
    logic needLoad;
    logic sdaOut;
    logic sdaOe;
    logic busy;
    reg_access_t acc;
  } port_state_t;

  bus_events_t ev;
  port_state_t st_reg;
  port_state_t st_next;
  logic [6:0] myAddr;

  i2c_line_sync syncInst (
    .clock(clock),
    .srst(srst),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .ifaceSelect(ifaceSelect),
    .addressStrapPin(addressStrapPin),
    .events(ev)
  );

  assign myAddr = ev.strapHigh ? ADDR_STRAP_HIGH : ADDR_STRAP_LOW;

  // Oversampled bus clock
  // Bit engine; sampling at 25 MHz covers 400 kHz with margin
  always_comb
  begin
    st_next = st_reg;
    st_next.acc.wrStrobe = 1'b0;
    st_next.acc.rdStrobe = 1'b0;
    // Fetch the byte one cycle after needLoad, set at the clock fall after the read strobe, then drive bit 7
    if (st_reg.needLoad)
    begin
      st_next.needLoad = 1'b0;
      st_next.shift = regRdData;
      st_next.sdaOe = ~regRdData[7];
      st_next.sdaOut = 1'b0;
    end
    // Port dormant unless select pin high
    if (!ev.selHigh)
    begin
      st_next.phase = IDLE;
      st_next.sdaOe = 1'b0;
      st_next.busy = 1'b0;
    end
    else if (ev.startSeen)
    begin
      st_next.phase = ADDR;
      // The clock fall that closes the start is not a data bit
      st_next.sawRise = 1'b0;
      st_next.bitCnt = BIT_COUNT_RESET;
      st_next.sdaOe = 1'b0;
      st_next.busy = 1'b1;
    end
    else if (ev.stopSeen)
    begin
      st_next.phase = IDLE;
      st_next.sdaOe = 1'b0;
      st_next.busy = 1'b0;
    end
    else
    begin
      unique case (st_reg.phase)
        IDLE:
        begin
          st_next.sdaOe = 1'b0;
        end
        ADDR, RXBYTE:
        begin
          if (ev.sclRise)
          begin
            st_next.shift = {st_reg.shift[6:0], ev.sdaLevel};
            st_next.sawRise = 1'b1;
          end
          // Count only falls that follow a sampled bit
          if (ev.sclFall && st_reg.sawRise)
          begin
            if (st_reg.bitCnt == 3'h0)
            begin
              st_next.ackDriven = 1'b1;
              st_next.phase = ACK;
              if (st_reg.phase == ADDR)
              begin
                st_next.readMode = st_reg.shift[0];
                st_next.gotPtr = 1'b0;
                // Foreign address: leave the line released and drop out
                if (st_reg.shift[7:1] != myAddr)
                begin
                  st_next.ackDriven = 1'b0;
                  st_next.phase = IDLE;
                end
                else if (st_reg.shift[0])
                begin
                  st_next.acc.rdStrobe = 1'b1;
                  st_next.acc.addr = st_reg.ptr;
                end
              end
              else if (!st_reg.gotPtr)
              begin
                // Register address byte loads the pointer
                st_next.ptr = st_reg.shift;
                st_next.gotPtr = 1'b1;
              end
              else
              begin
                // Each data byte written in turn
                st_next.acc.wrStrobe = 1'b1;
                st_next.acc.addr = st_reg.ptr;
                st_next.acc.wrData = st_reg.shift;
                st_next.ptr = st_reg.ptr + 8'h01;
              end
              st_next.sdaOe = st_next.ackDriven;
              st_next.sdaOut = 1'b0;
            end
            else
            begin
              st_next.bitCnt = st_reg.bitCnt - 3'h1;
            end
          end
        end
        ACK:
        begin
          // Release after the acknowledge clock
          if (ev.sclFall)
          begin
            st_next.ackDriven = 1'b0;
            st_next.sdaOe = 1'b0;
            st_next.bitCnt = BIT_COUNT_RESET;
            if (st_reg.readMode)
            begin
              st_next.phase = TXBYTE;
              st_next.needLoad = 1'b1;
              st_next.ptr = st_reg.ptr + 8'h01;
            end
            else
            begin
              st_next.phase = RXBYTE;
            end
          end
        end
        TXBYTE:
        begin
          // Open drain: enable only to pull low
          if (ev.sclFall)
          begin
            if (st_reg.bitCnt == 3'h0)
            begin
              st_next.sdaOe = 1'b0;
              st_next.phase = MACK;
            end
            else
            begin
              st_next.bitCnt = st_reg.bitCnt - 3'h1;
              st_next.shift = {st_reg.shift[6:0], 1'b0};
              st_next.sdaOe = ~st_reg.shift[6];
            end
          end
        end
        MACK:
        begin
          // Controller ack continues, no ack ends reading
          if (ev.sclRise)
          begin
            if (ev.sdaLevel)
            begin
              st_next.phase = IDLE;
            end
            else
            begin
              st_next.acc.rdStrobe = 1'b1;
              st_next.acc.addr = st_reg.ptr;
            end
          end
          if (ev.sclFall)
          begin
            st_next.phase = TXBYTE;
            st_next.bitCnt = BIT_COUNT_RESET;
            st_next.needLoad = 1'b1;
            st_next.ptr = st_reg.ptr + 8'h01;
          end
        end
      endcase
    end
  end

  // Pointer survives stop so a stop-start read resumes there
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      st_reg <= '0;
      st_reg.phase <= IDLE;
      st_reg.bitCnt <= BIT_COUNT_RESET;
      st_reg.ptr <= PTR_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign sdaOut = st_reg.sdaOut;
  assign sdaOe = st_reg.sdaOe;
  assign regAccess = st_reg.acc;
  assign busBusy = st_reg.busy;
endmodule

/* rtl/i2c_target_pkg.sv */
// Shared constants and carriers for the two-wire target port
package i2c_target_pkg;
  // Target addresses chosen by the strap pin
  localparam logic [6:0] ADDR_STRAP_HIGH = 7'h1D;
  localparam logic [6:0] ADDR_STRAP_LOW = 7'h53;
  // Bus speed limits, in kHz
  localparam int STD_RATE_KHZ = 100;
  localparam int FAST_RATE_KHZ = 400;
  // Register pointer width and reset value
  localparam int PTR_W = 8;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [2:0] BIT_COUNT_RESET = 3'h7;

  // Register-side access strobe bundle
  typedef struct packed {
    logic wrStrobe;
    logic rdStrobe;
    logic [7:0] addr;
    logic [7:0] wrData;
  } reg_access_t;

  // Synchronised and edge-decoded bus lines
  typedef struct packed {
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic sdaLevel;
    logic selHigh;
    logic strapHigh;
  } bus_events_t;
endpackage

/* rtl/i2c_line_sync.sv */
// Two-flop synchroniser and edge decoder for the bus lines and straps
`timescale 1ns/100ps
module i2c_line_sync
  import i2c_target_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic ifaceSelect,
  input wire logic addressStrapPin,
  output i2c_target_pkg::bus_events_t events
);
  typedef struct packed {
    logic [3:0] meta;
    logic [3:0] sync;
    logic sclOld;
    logic sdaOld;
    bus_events_t ev;
  } sync_state_t;

  sync_state_t st_reg;
  sync_state_t st_next;

  // Only the second stage is read by decode logic
  always_comb
  begin
    st_next = st_reg;
    st_next.meta = {sclIn, sdaIn, ifaceSelect, addressStrapPin};
    st_next.sync = st_reg.meta;
    st_next.sclOld = st_reg.sync[3];
    st_next.sdaOld = st_reg.sync[2];
    st_next.ev.sclRise = st_reg.sync[3] & ~st_reg.sclOld;
    st_next.ev.sclFall = ~st_reg.sync[3] & st_reg.sclOld;
    // Data edge while clock stays high marks start or stop
    st_next.ev.startSeen = st_reg.sync[3] & st_reg.sclOld & st_reg.sdaOld & ~st_reg.sync[2];
    st_next.ev.stopSeen = st_reg.sync[3] & st_reg.sclOld & ~st_reg.sdaOld & st_reg.sync[2];
    st_next.ev.sdaLevel = st_reg.sync[2];
    st_next.ev.selHigh = st_reg.sync[1];
    st_next.ev.strapHigh = st_reg.sync[0];
  end

  // Idle bus reads as high lines
  always_ff @(posedge clock)
  begin
    if (srst)
      st_reg <= '{meta: 4'hF, sync: 4'hF, sclOld: 1'b1, sdaOld: 1'b1, ev: '0};
    else
      st_reg <= st_next;
  end

  assign events = st_reg.ev;
endmodule

/* bench/i2c_ctrl_model.sv */
// Bus controller model driving clock and open-drain data
`timescale 1ns/100ps
module i2c_ctrl_model
(
  input wire logic clock,
  output logic scl,
  output logic sdaDrv,
  input wire logic sda
);
  // Quarter bus period in system clocks; 16 keeps fast mode under 400 kHz
  int quarter = 16;
  initial {scl, sdaDrv} = 2'b11;
  task automatic q();
    repeat (quarter) @(negedge clock);
  endtask
  task automatic start();
    sdaDrv = 1'b1;
    q();
    scl = 1'b1;
    q();
    sdaDrv = 1'b0;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic stop();
    sdaDrv = 1'b0;
    q();
    scl = 1'b1;
    q();
    sdaDrv = 1'b1;
    q();
  endtask
  task automatic xfer(input logic [7:0] d, input logic ack, output logic [7:0] r,
    output logic seen);
    for (int i = 8; i >= 0; i--)
    begin
      sdaDrv = (i == 0) ? ack : d[i-1];
      q();
      scl = 1'b1;
      q();
      if (i == 0)
        seen = sda;
      else
        r[i-1] = sda;
      q();
      scl = 1'b0;
      q();
    end
  endtask
endmodule

/* bench/sensor_i2c_target_port_sva.sv */
// Pin-level assertions for the two-wire target port
`timescale 1ns/100ps
module sensor_i2c_target_port_sva
  import i2c_target_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic ifaceSelect,
  input wire logic addressStrapPin,
  input wire i2c_target_pkg::reg_access_t regAccess,
  input wire logic [7:0] regRdData,
  input wire logic busBusy
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  logic seenWr_reg;
  logic [7:0] lastWr_reg;
  // Last write address, forgotten at each start
  always_ff @(posedge clock)
  begin
    if (srst || ($fell(sdaIn) && sclIn))
      seenWr_reg <= 1'b0;
    else if (regAccess.wrStrobe)
      seenWr_reg <= 1'b1;
    if (regAccess.wrStrobe)
      lastWr_reg <= regAccess.addr;
  end
  AST_OPEN_DRAIN: assert property (sdaOut == 1'b0)
    else $error("data drive value high");
  AST_DESEL_QUIET: assert property (!ifaceSelect [*6] |-> !sdaOe)
    else $error("data pulled while deselected");
  AST_BUSY_ON_START: assert property (ifaceSelect && $fell(sdaIn) && sclIn |-> ##[1:8] busBusy)
    else $error("start not decoded");
  AST_WR_SPACED: assert property ($rose(regAccess.wrStrobe) |=> !regAccess.wrStrobe [*8])
    else $error("write strobes too close");
  AST_RD_ALONE: assert property (regAccess.rdStrobe |-> !regAccess.wrStrobe ##1 !regAccess.rdStrobe)
    else $error("read strobe malformed");
  AST_PTR_STEP: assert property (regAccess.wrStrobe && seenWr_reg |-> regAccess.addr == lastWr_reg + 8'h01)
    else $error("pointer did not step");
  AST_DRIVE_IN_LOW: assert property ($rose(sdaOe) |-> !sclIn)
    else $error("data pulled while clock high");
  AST_HOLD_HIGH: assert property (sclIn [*6] |-> $stable(sdaOe))
    else $error("data drive changed in clock high");
  cover property (regAccess.wrStrobe);
  cover property (regAccess.rdStrobe);
  cover property (sdaOe && sclIn);
endmodule
bind sensor_i2c_target_port sensor_i2c_target_port_sva SVA (.clock(clock), .srst(srst),
  .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .ifaceSelect(ifaceSelect),
  .addressStrapPin(addressStrapPin), .regAccess(regAccess), .regRdData(regRdData),
  .busBusy(busBusy));

/* bench/tb_sensor_i2c_target_port.sv */
// Testbench for the two-wire target port
`timescale 1ns/100ps
module tb_sensor_i2c_target_port;
  import i2c_target_pkg::*;
  logic clock = 0, srst = 1, sel = 1, strap = 1, scl, sdaDrv, sdaOut, sdaOe, busBusy, a;
  logic [7:0] regRdData = 8'h00, r;
  logic [7:0] mem [256];
  int mismatches = 0, n_checks = 0;
  reg_access_t regAccess;
  // Open-drain data line with pull-up
  wire sda = sdaOe ? (sdaOut & sdaDrv) : sdaDrv;
  initial forever #20 clock = ~clock;
  sensor_i2c_target_port DUT (.clock(clock), .srst(srst), .sclIn(scl), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .ifaceSelect(sel), .addressStrapPin(strap),
    .regAccess(regAccess), .regRdData(regRdData), .busBusy(busBusy));
  i2c_ctrl_model M (.clock(clock), .scl(scl), .sdaDrv(sdaDrv), .sda(sda));
  // Register space, answering the cycle after a strobe
  always @(negedge clock)
  begin
    if (regAccess.rdStrobe === 1'b1) regRdData <= mem[regAccess.addr];
    if (regAccess.wrStrobe === 1'b1) mem[regAccess.addr] <= regAccess.wrData;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One byte out, then the ack bit compared (0 means acked)
  task automatic wb(input logic [7:0] d, input logic e);
    M.xfer(d, 1'b1, r, a);
    chk({7'h00, a}, {7'h00, e});
  endtask
  // Fast-mode rate, strap high, write then restart read
  task automatic t_strap_high();
    strap = 1;
    M.start();
    chk({7'h00, busBusy}, 8'h01);
    wb(8'h3A, 0);
    wb(8'h10, 0);
    wb(8'hA5, 0);
    wb(8'h3C, 0);
    M.stop();
    chk({7'h00, busBusy}, 8'h00);
    chk(mem[8'h11], 8'h3C);
    M.start();
    wb(8'h3A, 0);
    wb(8'h10, 0);
    M.start();
    wb(8'h3B, 0);
    M.xfer(8'hFF, 1'b0, r, a);
    chk(r, 8'hA5);
    M.xfer(8'hFF, 1'b1, r, a);
    chk(r, 8'h3C);
    M.stop();
  endtask
  // Standard-mode rate, strap low, stop-start read
  task automatic t_strap_low();
    strap = 0;
    M.quarter = 63;
    M.start();
    wb(8'h3A, 1);
    M.stop();
    M.start();
    wb(8'hA6, 0);
    wb(8'h20, 0);
    wb(8'h5A, 0);
    M.stop();
    M.start();
    wb(8'hA6, 0);
    wb(8'h20, 0);
    M.stop();
    M.start();
    wb(8'hA7, 0);
    M.xfer(8'hFF, 1'b1, r, a);
    chk(r, 8'h5A);
    M.stop();
    M.quarter = 16;
  endtask
  // Deselected port ignores a matching address
  task automatic t_deselect();
    sel = 0;
    M.start();
    chk({7'h00, busBusy}, 8'h00);
    wb(8'hA6, 1);
    M.stop();
    sel = 1;
    M.q();
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(negedge clock);
    srst = 0;
    repeat (4) @(negedge clock);
    t_strap_high();
    t_strap_low();
    t_deselect();
    stop_test();
  end
  // Bound on the whole run
  initial
  begin
    repeat (100000) @(posedge clock);
    mismatches++;
    stop_test();
  end
endmodule
